/* core/tbs_pkg.sv */
// Constants shared by the tape byte serializer and deserializer.
package tbs_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] OFS_READ_PORT   = 3'h0;
  localparam logic [2:0] OFS_WRITE_PORT  = 3'h1;
  localparam logic [2:0] OFS_CTRL        = 3'h2;
  localparam logic [2:0] OFS_STATUS_A    = 3'h3;
  localparam logic [2:0] OFS_KEYPAD      = 3'h4;
  localparam logic [2:0] OFS_EVENTS      = 3'h5;

  // Field positions in the control register.
  localparam int CTRL_DIR_WRITE_BIT      = 0;
  localparam int CTRL_WRITE_GATE_BIT     = 1;
  localparam int CTRL_MARK_GENERATE_BIT  = 2;

  // Field positions in the status and keypad registers.
  localparam int TIMER_DONE_BIT          = 0;
  localparam int LATCH_CLEAR_BIT         = 1;
  localparam int CARTRIDGE_ABSENT_BIT    = 6;

  // Field positions in the event register.
  localparam int EVT_WORD_REQUEST_BIT    = 0;
  localparam int EVT_RW_CTRL_LSB         = 1;
  localparam int EVT_STATUS_CTRL_LSB     = 3;
  localparam int EVT_WIDTH               = 7;

  // Values after reset.
  localparam logic       RST_DIR_WRITE   = 1'b1;
  localparam logic [7:0] RST_BYTE        = 8'h00;

  // Timer one-shot length and the width of its trigger pulse.
  localparam int CLK_MHZ                 = 50;
  localparam int TIMER_US                = 40;
  localparam int TIMER_CYC               = TIMER_US * CLK_MHZ;
  localparam logic [11:0] TIMER_CNT      = 12'(TIMER_CYC);
  localparam logic [2:0]  TRIG_PULSE_CNT = 3'h4;

endpackage : tbs_pkg

/* core/tbs_serdes.sv */
// Tape byte serializer and deserializer with write framing, timer and cartridge latch.
// Functional notes
// - Framing repeats eight bit clocks high then two low while writing.
// - Idle: write direction high, gate and marks low, framing low, clocks blocked.
// - Write gate rise: next bit clock arms and clears the cycle counter.
// - Second bit clock raises framing, releases counter, framing then holds.
// - Ones shift into the counter; tenth clock clears framing, cycle restarts.
// - Write strobe suppressed in the two low clocks, giving the character gap.
// - Write register loads the byte, shifts it out while framing is high.
// - Framing fall puts write register in load mode and requests a byte.
// - Gate lowered: finish the current cycle, then idle until it rises.
// - Reading: shared register shifts read data on strobes, byte to read port.
// - Shared register input is read data, or framing when writing.
// - Shared clock is read strobe or bit clock; write clocks only framing high.
// - Mark generation forces serial write data low.
// - Write strobe pulses on write register clock, or marks with timer pulse.
// - Timer pulse reaches write strobe only while generating marks.
// - Timer control idles high; read port read gives low pulse, 40 us one-shot.
// - One-shot output shows on status bit 0; low means interval done.
// - Cartridge removal sets a latch, shown as keypad status bit 6.
// - Toggling status bit 1 clears the cartridge latch.
// - Drive init output high on reset or while the cartridge latch is set.
// - Two read/write control lines and four status lines are event inputs.
`timescale 1ns/1ps
`default_nettype none

module tbs_serdes (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  input  wire logic       reg_re_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       tape_bit_clock_i,
  input  wire logic       read_data_i,
  input  wire logic       read_strobe_i,
  input  wire logic       cart_switch_n_i,
  input  wire logic [1:0] rw_ctrl_i,
  input  wire logic [3:0] status_ctrl_i,
  output logic            write_data_o,
  output logic            write_strobe_o,
  output logic            framing_o,
  output logic            word_request_o,
  output logic            timer_ctrl_o,
  output logic            drive_init_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    // Input synchronizers and edge flops.
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_s3;
    logic        rdat_s1;
    logic        rdat_s2;
    logic        rstb_s1;
    logic        rstb_s2;
    logic        rstb_s3;
    logic        cart_s1;
    logic        cart_s2;
    logic [5:0]  ctl_s1;
    logic [5:0]  ctl_s2;
    logic [5:0]  ctl_s3;

    // Software controls.
    logic        dir_write;
    logic        write_gate;
    logic        mark_generate;
    logic [7:0]  wbyte;
    logic        latch_clear;

    // Cartridge latch.
    logic        absent;

    // Write framing and shift registers.
    logic        arm;
    logic        framing;
    logic [7:0]  shared_sr;
    logic [7:0]  write_sr;

    // Head outputs and the word request.
    logic        wdata;
    logic        wstrobe;
    logic        request;

    // Event flags and timer.
    logic [6:0]  events;
    logic [2:0]  trig;
    logic [11:0] timer;

    // Read data and drive initialization.
    logic [7:0]  rdata;
    logic        init;
  } tbs_state_t;

  // Registered state and its next value.
  tbs_state_t st_q;
  tbs_state_t st_d;

  // Internal reset, released two clocks after the pin.
  logic       rst_s1_q;
  logic       rst_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic       bit_edge;
    logic       strobe_edge;
    logic       gated_edge;
    logic [5:0] ctl_edge;
    logic [6:0] evt_set;
    logic [6:0] evt_clr;
    logic [7:0] shifted;
    logic       mark_pulse;
    logic       latch_toggle;

    bit_edge     = 1'b0;
    strobe_edge  = 1'b0;
    gated_edge   = 1'b0;
    ctl_edge     = '0;
    evt_set      = '0;
    evt_clr      = '0;
    shifted      = '0;
    mark_pulse   = 1'b0;
    latch_toggle = 1'b0;
    st_d         = st_q;

    // Two flops on every input from outside the clock domain.
    // Bit clock, with a third flop for its edge.
    st_d.clk_s1  = tape_bit_clock_i;
    st_d.clk_s2  = st_q.clk_s1;
    st_d.clk_s3  = st_q.clk_s2;

    // Serial read data.
    st_d.rdat_s1 = read_data_i;
    st_d.rdat_s2 = st_q.rdat_s1;

    // Read strobe, with a third flop for its edge.
    st_d.rstb_s1 = read_strobe_i;
    st_d.rstb_s2 = st_q.rstb_s1;
    st_d.rstb_s3 = st_q.rstb_s2;

    // Cartridge switch level.
    st_d.cart_s1 = cart_switch_n_i;
    st_d.cart_s2 = st_q.cart_s1;

    // Control lines, with a third flop for their edges.
    st_d.ctl_s1  = {status_ctrl_i, rw_ctrl_i};
    st_d.ctl_s2  = st_q.ctl_s1;
    st_d.ctl_s3  = st_q.ctl_s2;

    // Rising edges of the synchronized bit clock, strobe and control lines.
    bit_edge    = st_q.clk_s2 & ~st_q.clk_s3;
    strobe_edge = st_q.rstb_s2 & ~st_q.rstb_s3;
    ctl_edge    = st_q.ctl_s2 & ~st_q.ctl_s3;

    gated_edge = bit_edge & st_q.dir_write & st_q.framing;

    if (bit_edge && st_q.dir_write) begin
      shifted = {st_q.shared_sr[6:0], st_q.framing};
      if (st_q.arm) begin
        st_d.arm       = 1'b0;
        st_d.framing   = 1'b1;
        st_d.shared_sr = shifted;
      end else if (!st_q.framing) begin
        st_d.arm       = st_q.write_gate;
        st_d.shared_sr = '0;
      end else begin
        st_d.shared_sr = shifted;
        if (shifted[7]) begin
          st_d.framing = 1'b0;
        end
      end
    end

    // Strobes in write direction are ignored.
    // read deserializer.
    if (strobe_edge && !st_q.dir_write) begin
      st_d.shared_sr = {st_q.shared_sr[6:0], st_q.rdat_s2};
    end

    if (gated_edge) begin
      st_d.write_sr = {st_q.write_sr[6:0], 1'b0};
    end else if (!st_q.framing) begin
      st_d.write_sr = st_q.wbyte;
    end

    st_d.wdata = st_q.write_sr[7] & ~st_q.mark_generate;

    mark_pulse = st_q.mark_generate & (st_q.trig != '0);

    st_d.wstrobe = gated_edge | mark_pulse;

    st_d.request = st_q.framing & ~st_d.framing;
    evt_set[tbs_pkg::EVT_WORD_REQUEST_BIT] = st_d.request;

    evt_set[tbs_pkg::EVT_RW_CTRL_LSB +: 2]     = ctl_edge[1:0];
    evt_set[tbs_pkg::EVT_STATUS_CTRL_LSB +: 4] = ctl_edge[5:2];

    if (st_q.trig != '0) begin
      st_d.trig = st_q.trig - 3'h1;
    end

    // The one-shot runs down to zero, which reads as done.
    if (st_q.timer != '0) begin
      st_d.timer = st_q.timer - 12'h001;
    end

    // Register port writes.
    if (reg_we_i) begin
      unique case (reg_addr_i)
        tbs_pkg::OFS_WRITE_PORT: begin
          // Byte for the next frame.
          st_d.wbyte = reg_wdata_i;
        end

        tbs_pkg::OFS_CTRL: begin
          st_d.dir_write     = reg_wdata_i[tbs_pkg::CTRL_DIR_WRITE_BIT];
          st_d.write_gate    = reg_wdata_i[tbs_pkg::CTRL_WRITE_GATE_BIT];
          st_d.mark_generate = reg_wdata_i[tbs_pkg::CTRL_MARK_GENERATE_BIT];
        end

        tbs_pkg::OFS_STATUS_A: begin
          st_d.latch_clear = reg_wdata_i[tbs_pkg::LATCH_CLEAR_BIT];
          latch_toggle     = st_d.latch_clear != st_q.latch_clear;
          if (latch_toggle) begin
            st_d.absent = 1'b0;
          end
        end

        tbs_pkg::OFS_EVENTS: begin
          // Writing ones clears event flags.
          evt_clr = reg_wdata_i[6:0];
        end

        default: ;
      endcase
    end

    if (!st_q.cart_s2) begin
      st_d.absent = 1'b1;
    end

    // Event flags: a new event wins over a software clear.
    st_d.events = (st_q.events & ~evt_clr) | evt_set;

    // Register port reads; data stand for one cycle, then zero.
    st_d.rdata = '0;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        tbs_pkg::OFS_READ_PORT: begin
          st_d.rdata = st_q.shared_sr;
          st_d.trig  = tbs_pkg::TRIG_PULSE_CNT;
          st_d.timer = tbs_pkg::TIMER_CNT;
        end

        tbs_pkg::OFS_WRITE_PORT: begin
          // The held write byte reads back.
          st_d.rdata = st_q.wbyte;
        end

        tbs_pkg::OFS_CTRL: begin
          // Control bits read back.
          st_d.rdata[tbs_pkg::CTRL_DIR_WRITE_BIT]     = st_q.dir_write;
          st_d.rdata[tbs_pkg::CTRL_WRITE_GATE_BIT]    = st_q.write_gate;
          st_d.rdata[tbs_pkg::CTRL_MARK_GENERATE_BIT] = st_q.mark_generate;
        end

        tbs_pkg::OFS_STATUS_A: begin
          st_d.rdata[tbs_pkg::TIMER_DONE_BIT]  = st_q.timer != '0;
          st_d.rdata[tbs_pkg::LATCH_CLEAR_BIT] = st_q.latch_clear;
        end

        tbs_pkg::OFS_KEYPAD: begin
          st_d.rdata[tbs_pkg::CARTRIDGE_ABSENT_BIT] = st_q.absent;
        end

        tbs_pkg::OFS_EVENTS: begin
          // Pending event flags.
          st_d.rdata = {1'b0, st_q.events};
        end

        default: ;
      endcase
    end

    st_d.init = st_q.absent;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset returns the write control to its idle state.
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q           <= '0;
      st_q.cart_s1   <= 1'b1;
      st_q.cart_s2   <= 1'b1;
      st_q.dir_write <= tbs_pkg::RST_DIR_WRITE;
      st_q.wbyte     <= tbs_pkg::RST_BYTE;
      st_q.init      <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Read data, one cycle after the read strobe.
  assign reg_rdata_o    = st_q.rdata;

  // Serial write data to the head.
  assign write_data_o   = st_q.wdata;

  // Write strobe to the head.
  assign write_strobe_o = st_q.wstrobe;

  // Framing waveform.
  assign framing_o      = st_q.framing;

  // One-cycle request for the next byte.
  assign word_request_o = st_q.request;

  // Timer control, low while the trigger pulse runs.
  assign timer_ctrl_o   = st_q.trig == '0;

  // Drive initialization level.
  assign drive_init_o   = st_q.init;

endmodule : tbs_serdes

`default_nettype wire

/* sim/tbs_serdes_props.sv */
// Concurrent checks on the tape byte serializer ports.
`timescale 1ns/1ps
`default_nettype none
module tbs_serdes_props (
  input wire logic       sys_clk_i,
  input wire logic       arst_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic       reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       tape_bit_clock_i,
  input wire logic       cart_switch_n_i,
  input wire logic       write_strobe_o,
  input wire logic       framing_o,
  input wire logic       word_request_o,
  input wire logic       timer_ctrl_o,
  input wire logic       drive_init_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic       bclk_q;
  logic [3:0] hi_cnt_q;
  // Counts raw bit clock rises while framing is high.
  always_ff @(posedge sys_clk_i) begin
    bclk_q <= tape_bit_clock_i;
    if (!framing_o) begin
      hi_cnt_q <= 4'h0;
    end else if (tape_bit_clock_i && !bclk_q) begin
      hi_cnt_q <= hi_cnt_q + 4'h1;
    end
  end
  sequence s_read_port;
    reg_re_i && reg_addr_i == 3'h0;
  endsequence
  sequence s_pulse_low;
    !timer_ctrl_o [*4] ##1 timer_ctrl_o;
  endsequence
  a_timer_pulse: assert property (s_read_port |=> s_pulse_low)
    else $error("timer pulse wrong");
  a_timer_cause: assert property ($fell(timer_ctrl_o) |-> $past(reg_re_i) &&
    $past(reg_addr_i) == 3'h0) else $error("timer pulse without read");
  a_frame_len: assert property ($fell(framing_o) |-> hi_cnt_q == 4'h8)
    else $error("framing high length wrong");
  a_wreq_fall: assert property ($fell(framing_o) |-> ##[0:1] word_request_o)
    else $error("no word request at framing fall");
  a_wreq_once: assert property (word_request_o |=> !word_request_o)
    else $error("word request too long");
  a_strobe_gap: assert property (write_strobe_o |-> framing_o || $past(framing_o) ||
    !timer_ctrl_o || !$past(timer_ctrl_o)) else $error("strobe in gap");
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_init_cart: assert property (!cart_switch_n_i |-> ##[1:4] drive_init_o)
    else $error("drive init missing on removal");
endmodule : tbs_serdes_props
`default_nettype wire

/* sim/tbs_head_model.sv */
// Behavioural tape head: bit clock, serial read source, write capture.
`timescale 1ns/1ps
`default_nettype none
module tbs_head_model (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic wr_data_i,
  input  wire logic wr_strobe_i,
  output logic      bit_clk_o,
  output logic      rd_data_o,
  output logic      rd_strobe_o
);
  logic [7:0] cap;
  int         ncap;
  initial begin
    bit_clk_o = 1'b0;
    rd_data_o = 1'b0;
    rd_strobe_o = 1'b0;
    #3;
    forever begin
      #80;
      bit_clk_o = run_i ? ~bit_clk_o : 1'b0;
    end
  end
  always @(posedge clk_i) begin
    if (wr_strobe_i) begin
      cap = {cap[6:0], wr_data_i};
      ncap = ncap + 1;
    end
  end
  task send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rd_data_o = b[i];
      #100 rd_strobe_o = 1'b1;
      #100 rd_strobe_o = 1'b0;
    end
    rd_data_o = ~b[0];
  endtask : send_byte
endmodule : tbs_head_model
`default_nettype wire

/* sim/tbs_serdes_test.sv */
// Self-checking bench for the tape byte serializer.
`timescale 1ns/1ps
`default_nettype none
module tbs_serdes_test;
  logic       clk, rst_n, we, re, bclk, rdat, rstb, cart_n, run;
  logic       wdat, wstb, frm, wreq, tmr, init;
  logic [2:0] addr;
  logic [7:0] wd, rdata;
  logic [1:0] rwc;
  logic [3:0] stc;
  int         num_errors, n_tests;
  always #10 clk = ~clk;
  tbs_serdes dut_u (.sys_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .tape_bit_clock_i(bclk),
    .read_data_i(rdat), .read_strobe_i(rstb), .cart_switch_n_i(cart_n), .rw_ctrl_i(rwc),
    .status_ctrl_i(stc), .write_data_o(wdat), .write_strobe_o(wstb), .framing_o(frm),
    .word_request_o(wreq), .timer_ctrl_o(tmr), .drive_init_o(init));
  tbs_head_model head_u (.clk_i(clk), .run_i(run), .wr_data_i(wdat), .wr_strobe_i(wstb),
    .bit_clk_o(bclk), .rd_data_o(rdat), .rd_strobe_o(rstb));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  task wait_hi(input logic sel);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (sel ? frm : wreq) break;
    end
    chk({7'h0, sel ? frm : wreq}, 8'h01);
  endtask : wait_hi
  task t_reset;
    rd(3'h2, 8'h01);
    wr(3'h7, 8'hff);
    rd(3'h1, 8'h00);
    rd(3'h6, 8'h00);
    chk({6'h0, frm, wstb}, 8'h00);
  endtask : t_reset
  task t_write;
    wr(3'h1, 8'ha5);
    head_u.ncap = 0;
    run <= 1'b1;
    wr(3'h2, 8'h03);
    wait_hi(1'b0);
    @(posedge clk);
    #1;
    chk(head_u.cap, 8'ha5);
    chk(8'(head_u.ncap), 8'h08);
    wr(3'h1, 8'h3c);
    head_u.ncap = 0;
    wait_hi(1'b1);
    wr(3'h2, 8'h01);
    wait_hi(1'b0);
    @(posedge clk);
    #1;
    chk(head_u.cap, 8'h3c);
    chk(8'(head_u.ncap), 8'h08);
    repeat (200) @(posedge clk);
    chk({7'h0, frm}, 8'h00);
    run <= 1'b0;
    rd(3'h5, 8'h7f);
    wr(3'h5, 8'h7f);
    rd(3'h5, 8'h00);
  endtask : t_write
  task t_read;
    wr(3'h2, 8'h00);
    head_u.send_byte(8'h96);
    repeat (4) @(posedge clk);
    rd(3'h0, 8'h96);
    chk({7'h0, tmr}, 8'h00);
    rd(3'h3, 8'h01);
    repeat (2000) @(posedge clk);
    rd(3'h3, 8'h00);
  endtask : t_read
  task t_marks;
    wr(3'h2, 8'h05);
    head_u.ncap = 0;
    rd(3'h0, 8'h96);
    repeat (8) @(posedge clk);
    chk(8'(head_u.ncap), 8'h04);
    chk({head_u.cap[3:0], 3'h0, wdat}, 8'h00);
    wr(3'h2, 8'h01);
    head_u.ncap = 0;
    rd(3'h0, 8'h96);
    repeat (8) @(posedge clk);
    chk(8'(head_u.ncap), 8'h00);
  endtask : t_marks
  task t_cart;
    cart_n <= 1'b0;
    repeat (6) @(posedge clk);
    cart_n <= 1'b1;
    rd(3'h4, 8'h40);
    chk({7'h0, init}, 8'h01);
    wr(3'h3, 8'h02);
    wr(3'h3, 8'h00);
    rd(3'h4, 8'h00);
    chk({7'h0, init}, 8'h00);
  endtask : t_cart
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {clk, rst_n, we, re, run, addr, wd, rwc, stc} = '0;
    cart_n = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rwc <= 2'h3;
    stc <= 4'hf;
    t_reset;
    t_write;
    t_read;
    t_marks;
    t_cart;
    print_verdict;
  end
  initial begin
    #200us;
    num_errors++;
    print_verdict;
  end
endmodule : tbs_serdes_test
bind tbs_serdes tbs_serdes_props chk_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .tape_bit_clock_i(tape_bit_clock_i), .cart_switch_n_i(cart_switch_n_i),
  .write_strobe_o(write_strobe_o), .framing_o(framing_o), .word_request_o(word_request_o),
  .timer_ctrl_o(timer_ctrl_o), .drive_init_o(drive_init_o));
`default_nettype wire
